//--- brc_pkg.sv
// Package for the bank 6/7 configuration and refresh block.
// Assumes one bus clock for registers, timing and refresh.
package brc_pkg;

    ////////////////////////////////////////////////////////////////
    // Register byte addresses
    localparam logic [31:0] BANK6_OFS = 32'h01c8001c;
    localparam logic [31:0] BANK7_OFS = 32'h01c80020;
    localparam logic [31:0] RFSH_OFS  = 32'h01c80024;
    localparam logic [31:0] SIZE_OFS  = 32'h01c80028;

    ////////////////////////////////////////////////////////////////
    // Reset values and writable masks
    localparam logic [31:0] BANK_RST  = 32'h00018008;
    localparam logic [31:0] RFSH_RST  = 32'h00ac0000;
    localparam logic [31:0] SIZE_RST  = 32'h00000000;
    localparam logic [31:0] BANK_MASK = 32'h0001ffff;
    localparam logic [31:0] RFSH_MASK = 32'h00ff07ff;
    localparam logic [31:0] SIZE_MASK = 32'h00000017;

    ////////////////////////////////////////////////////////////////
    // Field positions
    localparam int MT_LSB    = 15;
    localparam int TACS_LSB  = 13;
    localparam int TCOS_LSB  = 11;
    localparam int TACC_LSB  = 8;
    localparam int TOCH_LSB  = 6;
    localparam int TCAH_LSB  = 4;
    localparam int TPAC_LSB  = 2;
    localparam int PAGE_LSB  = 0;
    localparam int DTRCD_LSB = 4;
    localparam int TCAS_BIT  = 3;
    localparam int TCP_BIT   = 2;
    localparam int STRCD_LSB = 2;
    localparam int COL_LSB   = 0;
    localparam int RF_ON_BIT = 23;
    localparam int RF_SELF   = 22;
    localparam int TRP_LSB   = 20;
    localparam int TRC_LSB   = 18;
    localparam int TCHR_LSB  = 16;
    localparam int RCNT_LSB  = 0;
    localparam int RCNT_W    = 11;
    localparam int GATE_BIT  = 4;
    localparam int MAP_LSB   = 0;

    ////////////////////////////////////////////////////////////////
    // Memory types and timing base
    localparam logic [1:0] MT_STATIC_ROM_OR_RAM  = 2'h0;
    localparam logic [1:0] MT_FPDR  = 2'h1;
    localparam logic [1:0] MT_EDO   = 2'h2;
    localparam logic [1:0] MT_SDRAM = 2'h3;
    localparam int RFSH_BASE = 2049;

    // Decoded timing of one bank, counts in bus clocks except page_run_length and col_bits
    typedef struct packed {
        logic [1:0] mem_type;
        logic [2:0] addr_setup;
        logic [2:0] cs_to_oe;
        logic [3:0] access_clk;
        logic [2:0] cs_hold;
        logic [2:0] addr_hold;
        logic [2:0] page_clk;
        logic [4:0] page_run_length;
        logic [2:0] row_to_col;
        logic [1:0] col_pulse;
        logic [1:0] col_precharge;
        logic [3:0] col_bits;
    } brc_bank_t;

    // Refresh pin levels
    typedef struct packed {
        logic row_strobe_n;
        logic col_strobe_n;
        logic clock_enable;
    } brc_pins_t;

endpackage : brc_pkg

//--- brc_bank67.sv
// Bank 6/7 configuration, refresh generator and clock gate control.
// Assumes an AHB-Lite master and a memory sequencer on sys_clk.
//
// Notes on behaviour
// - Bits 16:15 select bank memory type
// - STATIC_ROM_OR_RAM address setup 0,1,2,4 clocks
// - STATIC_ROM_OR_RAM select to output enable delay
// - STATIC_ROM_OR_RAM access 1..14 clocks, reset 000
// - STATIC_ROM_OR_RAM select hold after output enable
// - STATIC_ROM_OR_RAM address hold after select
// - STATIC_ROM_OR_RAM page cycle 2,3,4,6 clocks
// - STATIC_ROM_OR_RAM page runs of 1,4,8,16
// - DRAM row to column delay 1..4
// - DRAM column pulse and precharge width
// - DRAM column bits 8 to 11
// - SDRAM row to column 2..5 clocks
// - SDRAM column bits 8 to 11
// - Bit 23 enables refresh, reset on
// - Bit 22 selects self refresh mode
// - Row precharge time per memory kind
// - SDRAM row cycle 4..7 clocks
// - DRAM column hold during refresh
// - Refresh every 2049 minus count clocks
// - Gate SDRAM clock outside accesses and refreshes
// - Equal upper bank size map
// - All counts in bus clocks except page run length and column bits
//
// Chosen here: the AHB-Lite register port.
module brc_bank67 (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              arst_n,
    // AHB-Lite slave
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic [31:0]            hrdata,
    // Memory sequencer
    input  wire logic              access_busy,
    input  wire logic              sdram_access,
    output brc_pkg::brc_bank_t     bank6_timing,
    output brc_pkg::brc_bank_t     bank7_timing,
    output logic [5:0]             upper_bank_size_mb,
    output logic                   refresh_busy,
    // Memory pins
    output brc_pkg::brc_pins_t     refresh_pins,
    output logic                   sdram_clk_en
);

    ////////////////////////////////////////////////////////////////
    // Reset release
    logic rst_q1_r;
    logic rst_n;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_q1_r <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_q1_r <= 1'b1;
            rst_n    <= rst_q1_r;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Bus slave
    logic [31:0] bank6_r;
    logic [31:0] bank7_r;
    logic [31:0] rfsh_r;
    logic [31:0] size_r;
    logic [31:0] addr_r;
    logic        wr_pend_r;
    logic        rd_pend_r;
    logic        rd_wait_r;
    logic [31:0] rd_val;
    logic        take;

    assign take = hsel && htrans[1] && hready;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_r    <= 32'h0;
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
        end else if (hready) begin
            addr_r    <= haddr;
            wr_pend_r <= take && hwrite;
            rd_pend_r <= take && !hwrite;
        end
    end

    // Reads take one wait state so hrdata can be registered from rd_val
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_wait_r <= 1'b0;
        end else begin
            rd_wait_r <= hready && take && !hwrite;
        end
    end

    assign hreadyout = !rd_wait_r;
    assign hresp     = 1'b0;

    always_comb begin
        rd_val = 32'h0;
        if (addr_r == brc_pkg::BANK6_OFS) begin
            rd_val = bank6_r;
        end else if (addr_r == brc_pkg::BANK7_OFS) begin
            rd_val = bank7_r;
        end else if (addr_r == brc_pkg::RFSH_OFS) begin
            rd_val = rfsh_r;
        end else if (addr_r == brc_pkg::SIZE_OFS) begin
            rd_val = size_r;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hrdata <= 32'h0;
        end else if (rd_wait_r && rd_pend_r) begin
            hrdata <= rd_val;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bank6_r <= brc_pkg::BANK_RST;
            bank7_r <= brc_pkg::BANK_RST;
            rfsh_r  <= brc_pkg::RFSH_RST;
            size_r  <= brc_pkg::SIZE_RST;
        end else if (wr_pend_r) begin
            if (addr_r == brc_pkg::BANK6_OFS) begin
                bank6_r <= hwdata & brc_pkg::BANK_MASK;
            end else if (addr_r == brc_pkg::BANK7_OFS) begin
                bank7_r <= hwdata & brc_pkg::BANK_MASK;
            end else if (addr_r == brc_pkg::RFSH_OFS) begin
                rfsh_r <= hwdata & brc_pkg::RFSH_MASK;
            end else if (addr_r == brc_pkg::SIZE_OFS) begin
                size_r <= hwdata & brc_pkg::SIZE_MASK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Field decode
    function automatic logic [2:0] clk0124(input logic [1:0] c);
        clk0124 = (c == 2'h3) ? 3'h4 : {1'b0, c};
    endfunction : clk0124

    function automatic brc_pkg::brc_bank_t decode(input logic [31:0] r);
        logic [1:0] mt;
        logic [2:0] acc;
        logic [1:0] pg;
        mt = r[brc_pkg::MT_LSB +: 2];
        acc = r[brc_pkg::TACC_LSB +: 3];
        pg = r[brc_pkg::PAGE_LSB +: 2];
        decode = '0;
        decode.mem_type = mt;
        if (mt == brc_pkg::MT_STATIC_ROM_OR_RAM) begin
            decode.addr_setup = clk0124(r[brc_pkg::TACS_LSB +: 2]);
            decode.cs_to_oe = clk0124(r[brc_pkg::TCOS_LSB +: 2]);
            case (acc)
                3'h4: decode.access_clk = 4'h6;
                3'h5: decode.access_clk = 4'h8;
                3'h6: decode.access_clk = 4'ha;
                3'h7: decode.access_clk = 4'he;
                default: decode.access_clk = {1'b0, acc} + 4'h1;
            endcase
            decode.cs_hold = clk0124(r[brc_pkg::TOCH_LSB +: 2]);
            decode.addr_hold = clk0124(r[brc_pkg::TCAH_LSB +: 2]);
            decode.page_clk = (r[brc_pkg::TPAC_LSB +: 2] == 2'h3) ? 3'h6
                            : {1'b0, r[brc_pkg::TPAC_LSB +: 2]} + 3'h2;
            decode.page_run_length = (pg == 2'h0) ? 5'h01 : (5'h02 << pg);
        end else if (mt == brc_pkg::MT_SDRAM) begin
            decode.row_to_col = {1'b0, r[brc_pkg::STRCD_LSB +: 2]} + 3'h2;
            decode.col_bits = {2'h0, r[brc_pkg::COL_LSB +: 2]} + 4'h8;
        end else begin
            decode.row_to_col = {1'b0, r[brc_pkg::DTRCD_LSB +: 2]} + 3'h1;
            decode.col_pulse = r[brc_pkg::TCAS_BIT] ? 2'h2 : 2'h1;
            decode.col_precharge = r[brc_pkg::TCP_BIT] ? 2'h2 : 2'h1;
            decode.col_bits = {2'h0, r[brc_pkg::COL_LSB +: 2]} + 4'h8;
        end
    endfunction : decode

    ////////////////////////////////////////////////////////////////
    // Timing outputs, refreshed only between accesses
    logic [2:0] map_code;
    logic       idle_rf;

    assign map_code = size_r[brc_pkg::MAP_LSB +: 3];

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bank6_timing       <= '0;
            bank7_timing       <= '0;
            upper_bank_size_mb <= 6'h0;
        end else if (!access_busy && idle_rf) begin
            bank6_timing <= decode(bank6_r);
            bank7_timing <= decode(bank7_r);
            case (map_code)
                3'h4: upper_bank_size_mb <= 6'h02;
                3'h5: upper_bank_size_mb <= 6'h04;
                3'h6: upper_bank_size_mb <= 6'h08;
                3'h7: upper_bank_size_mb <= 6'h10;
                default: upper_bank_size_mb <= 6'h20;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // Refresh interval
    logic [1:0]  mt6;
    logic [1:0]  mt7;
    logic        any_dram;
    logic        any_sd;
    logic        rf_on;
    logic        rf_self;
    logic [11:0] period;
    logic [11:0] tick_cnt_r;
    logic        tick;

    assign mt6      = bank6_r[brc_pkg::MT_LSB +: 2];
    assign mt7      = bank7_r[brc_pkg::MT_LSB +: 2];
    // mixed DRAM and SDRAM not handled
    assign any_sd   = (mt6 == brc_pkg::MT_SDRAM) || (mt7 == brc_pkg::MT_SDRAM);
    assign any_dram = (mt6 != brc_pkg::MT_STATIC_ROM_OR_RAM) || (mt7 != brc_pkg::MT_STATIC_ROM_OR_RAM);
    assign rf_on    = rfsh_r[brc_pkg::RF_ON_BIT] && any_dram;
    assign rf_self  = rfsh_r[brc_pkg::RF_SELF];
    assign period   = 12'(brc_pkg::RFSH_BASE)
                    - {1'b0, rfsh_r[brc_pkg::RCNT_LSB +: brc_pkg::RCNT_W]};
    assign tick     = rf_on && !rf_self && (tick_cnt_r == 12'h0);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_r <= 12'h0;
        end else if (!rf_on || rf_self || tick_cnt_r == 12'h0) begin
            tick_cnt_r <= period - 12'h1;
        end else begin
            tick_cnt_r <= tick_cnt_r - 12'h1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Refresh sequencer
    typedef enum logic [2:0] {RF_IDLE, RF_CAS, RF_RAS, RF_PRE, RF_SLEEP} brc_rf_t;

    brc_rf_t   state_r;
    brc_rf_t   state_nxt;
    logic [2:0] cnt_r;
    logic [2:0] cnt_nxt;
    logic [2:0] trp_clk;
    logic [2:0] trc_clk;
    logic [2:0] tchr_clk;

    assign trp_clk  = any_sd
                    ? ((rfsh_r[brc_pkg::TRP_LSB +: 2] == 2'h3) ? 3'h4
                       : {1'b0, rfsh_r[brc_pkg::TRP_LSB +: 2]} + 3'h2)
                    : {1'b0, rfsh_r[brc_pkg::TRP_LSB +: 2]} + 3'h2;
    assign trc_clk  = {1'b0, rfsh_r[brc_pkg::TRC_LSB +: 2]} + 3'h4;
    assign tchr_clk = {1'b0, rfsh_r[brc_pkg::TCHR_LSB +: 2]} + 3'h1;
    assign idle_rf  = (state_r == RF_IDLE);

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = (cnt_r == 3'h0) ? 3'h0 : cnt_r - 3'h1;
        case (state_r)
            RF_IDLE: begin
                if (rf_on && rf_self && !access_busy) begin
                    state_nxt = RF_SLEEP;
                end else if (tick && !access_busy) begin
                    state_nxt = any_sd ? RF_RAS : RF_CAS;
                    cnt_nxt   = any_sd ? 3'h0 : 3'h0;
                end
            end
            RF_CAS: begin
                state_nxt = RF_RAS;
                cnt_nxt   = tchr_clk - 3'h1;
            end
            RF_RAS: begin
                if (cnt_r == 3'h0) begin
                    state_nxt = RF_PRE;
                    cnt_nxt   = any_sd ? trc_clk - 3'h2 : trp_clk - 3'h1;
                end
            end
            RF_PRE: begin
                if (cnt_r == 3'h0) begin
                    state_nxt = RF_IDLE;
                end
            end
            RF_SLEEP: begin
                if (!rf_on || !rf_self) begin
                    state_nxt = RF_PRE;
                    cnt_nxt   = trp_clk - 3'h1;
                end
            end
            default: begin
                state_nxt = RF_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= RF_IDLE;
            cnt_r   <= 3'h0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    // Pins registered from the next state to avoid glitches
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            refresh_pins <= '{1'b1, 1'b1, 1'b1};
        end else begin
            refresh_pins.col_strobe_n <= !(state_nxt == RF_CAS
                                        || state_nxt == RF_RAS
                                        || state_nxt == RF_SLEEP);
            refresh_pins.row_strobe_n <= !(state_nxt == RF_RAS
                                        || state_nxt == RF_SLEEP);
            // held low while SDRAM self refreshes
            refresh_pins.clock_enable <= !(any_sd && state_nxt == RF_SLEEP);
        end
    end

    assign refresh_busy = !idle_rf;

    ////////////////////////////////////////////////////////////////
    // SDRAM clock gate
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sdram_clk_en <= 1'b1;
        end else begin
            sdram_clk_en <= !size_r[brc_pkg::GATE_BIT] || sdram_access
                         || (state_nxt != RF_IDLE && state_nxt != RF_SLEEP);
        end
    end

endmodule : brc_bank67

//--- brc_bank67_sva.sv
// Checker for brc_bank67, bound to its ports.
// Assumes hready is fed from this slave's hreadyout.
module brc_sva (
    // Clock and reset
    input wire logic               sys_clk,
    input wire logic               arst_n,
    // Bus
    input wire logic               hsel,
    input wire logic [1:0]         htrans,
    input wire logic               hwrite,
    input wire logic               hready,
    input wire logic               hreadyout,
    input wire logic               hresp,
    input wire logic [31:0]        hrdata,
    // Sequencer and pins
    input wire logic               access_busy,
    input wire logic               sdram_access,
    input wire brc_pkg::brc_bank_t bank6_timing,
    input wire logic               refresh_busy,
    input wire brc_pkg::brc_pins_t refresh_pins,
    input wire logic               sdram_clk_en
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);
    logic take;
    logic rd_ph_r;
    assign take = hsel && htrans[1] && hready;
    // Marks a read data phase, held through its wait state
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_ph_r <= 1'b0;
        end else if (hready) begin
            rd_ph_r <= take && !hwrite;
        end
    end
    ////////////////////////////////////////////////////////////
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("Response not okay");
    a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("Read wait state wrong");
    a_write_fast: assert property (take && hwrite |=> hreadyout)
        else $error("Write stalled");
    a_wait_cause: assert property (!hreadyout |-> $past(take && !hwrite))
        else $error("Stray wait state");
    a_data_hold: assert property ($changed(hrdata) |-> rd_ph_r || $past(rd_ph_r))
        else $error("Read data moved outside a read");
    a_clk_follow: assert property (sdram_access |=> sdram_clk_en)
        else $error("Memory clock gated during access");
    a_start_idle: assert property ($rose(refresh_busy) |-> !$past(access_busy))
        else $error("Refresh started over an access");
    a_timing_frozen: assert property ($past(access_busy) |-> $stable(bank6_timing))
        else $error("Timing changed during an access");
    a_strobe_idle: assert property (!refresh_busy [*2] |->
        refresh_pins.row_strobe_n && refresh_pins.col_strobe_n)
        else $error("Strobes low outside refresh");
    c_read: cover property (take && !hwrite);
    c_refresh: cover property ($rose(refresh_busy));
    c_self: cover property (!refresh_pins.clock_enable);
endmodule : brc_sva

bind brc_bank67 brc_sva brc_sva_inst (.sys_clk(sys_clk), .arst_n(arst_n), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .access_busy(access_busy), .sdram_access(sdram_access),
    .bank6_timing(bank6_timing), .refresh_busy(refresh_busy), .refresh_pins(refresh_pins),
    .sdram_clk_en(sdram_clk_en));

//--- brc_mem_model.sv
// Sequencer stand-in: runs external accesses on request.
// Assumes the bench pulses go for one clock per access.
module brc_mem_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Requests from the bench
    input wire logic go,
    input wire logic slow,
    input wire logic sdram,
    // Block side
    input wire logic refresh_busy,
    output logic     access_busy,
    output logic     sdram_access
);
    logic [4:0] left_r;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            left_r <= 5'h0;
        end else if (go && !refresh_busy && left_r == 5'h0) begin
            left_r <= slow ? 5'h14 : 5'h03;
        end else if (left_r != 5'h0) begin
            left_r <= left_r - 5'h1;
        end
    end
    // Never starts while refresh_busy is high, as real arbitration would not
    assign access_busy  = (left_r != 5'h0);
    assign sdram_access = access_busy && sdram;
endmodule : brc_mem_model

//--- brc_bank67_tb.sv
// Bench: bus tasks, decode, refresh and clock gating checks.
// Assumes the sequencer stand-in idles unless asked for an access.
module brc_bank67_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, hready, hreadyout, hresp, access_busy, sdram_access, refresh_busy;
    logic arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, go = 1'b0, slow = 1'b0, sdram = 1'b0;
    logic [1:0] htrans = 2'h0, c, mt;
    logic [2:0] hsize = 3'h2, t;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, seen;
    logic sdram_clk_en;
    logic [5:0] size_mb;
    brc_pkg::brc_bank_t b6, b7;
    brc_pkg::brc_pins_t pins;
    int fail_count = 0, n_checks = 0, cyc = 0, b, p, cbr;
    int d4[4] = '{0, 1, 2, 4};
    int tpac[4] = '{2, 3, 4, 6};
    int runs[4] = '{1, 4, 8, 16};
    int tacc[8] = '{1, 2, 3, 4, 6, 8, 10, 14};
    int mapc[5] = '{0, 4, 5, 6, 7};
    int mapm[5] = '{32, 2, 4, 8, 16};
    assign hready = hreadyout;
    brc_bank67 brc_bank67_inst (.sys_clk(sys_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .access_busy(access_busy),
        .sdram_access(sdram_access), .bank6_timing(b6), .bank7_timing(b7),
        .upper_bank_size_mb(size_mb), .refresh_busy(refresh_busy), .refresh_pins(pins),
        .sdram_clk_en(sdram_clk_en));
    brc_mem_model brc_mem_model_inst (.sys_clk(sys_clk), .arst_n(arst_n), .go(go),
        .slow(slow), .sdram(sdram), .refresh_busy(refresh_busy), .access_busy(access_busy),
        .sdram_access(sdram_access));
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            wrap_up();
        end
    end
    ////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wrap_up();
        if (fail_count == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up
    // Ready and read data taken at the rising edge; only the bench timeout ends a wait
    task automatic wait_rdy();
        @(posedge sys_clk);
        while (hready !== 1'b1) begin
            @(posedge sys_clk);
        end
        seen = hrdata;
    endtask : wait_rdy
    task automatic addr_ph(input logic [31:0] a, input logic w);
        @(posedge sys_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        wait_rdy();
        htrans <= 2'h0;
    endtask : addr_ph
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        addr_ph(a, 1'b1);
        hwdata <= d;
        wait_rdy();
    endtask : wr
    task automatic rd(input logic [31:0] a);
        addr_ph(a, 1'b0);
        wait_rdy();
    endtask : rd
    // Busy length, full period and whether the column strobe led
    task automatic span();
        logic hit;
        hit = 1'b0;
        b = 0;
        p = 0;
        while (refresh_busy === 1'b1 && p < 3000) begin
            if (!hit && !(pins.row_strobe_n && pins.col_strobe_n)) begin
                hit = 1'b1;
                cbr = pins.row_strobe_n;
            end
            @(negedge sys_clk);
            b++;
            p++;
        end
        while (refresh_busy !== 1'b1 && p < 3000) begin
            @(negedge sys_clk);
            p++;
        end
    endtask : span
    task automatic rf_run(input logic [31:0] bank, input logic [10:0] cnt, input int ord);
        wr(brc_pkg::BANK6_OFS, bank);
        wr(brc_pkg::RFSH_OFS, {8'h00, 8'h80, 5'h0, cnt});
        @(negedge sys_clk);
        span();
        span();
        chk("period", 2049 - cnt, p);
        chk("order", ord, cbr);
        chk("busy", 4, b);
    endtask : rf_run
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rd(brc_pkg::BANK6_OFS);
        chk("b6 rst", 32'h00018008, seen);
        rd(brc_pkg::BANK7_OFS);
        chk("b7 rst", 32'h00018008, seen);
        rd(brc_pkg::RFSH_OFS);
        chk("rf rst", 32'h00ac0000, seen);
        rd(brc_pkg::SIZE_OFS);
        chk("sz rst", 32'h0, seen);
        chk("sd rcd", 4, b6.row_to_col);
        wr(brc_pkg::RFSH_OFS, 32'h007fffff);
        rd(brc_pkg::RFSH_OFS);
        chk("rf rsv", 32'h007f07ff, seen);
        wr(brc_pkg::BANK7_OFS, 32'hffffffff);
        rd(brc_pkg::BANK7_OFS);
        chk("b7 rsv", 32'h0001ffff, seen);
        wr(32'h01c8002c, 32'hffffffff);
        rd(32'h01c8002c);
        chk("unmap", 32'h0, seen);
        for (int i = 0; i < 8; i++) begin
            c = i[1:0];
            t = i[2:0];
            mt = i[0] ? 2'h2 : 2'h1;
            wr(brc_pkg::BANK6_OFS, {17'h0, c, c, t, c, c, c, c});
            // static bank beside DRAM or SDRAM only
            wr(brc_pkg::BANK7_OFS, i < 3 ? {17'h3, 11'h0, c, c} : {15'h0, mt, 9'h0, c, c[0], c[1], c});
            repeat (8) @(negedge sys_clk);
            chk("acc", tacc[i], b6.access_clk);
            chk("setup", d4[c], b6.addr_setup);
            chk("cs oe", d4[c], b6.cs_to_oe);
            chk("cs hold", d4[c], b6.cs_hold);
            chk("a hold", d4[c], b6.addr_hold);
            chk("page", tpac[c], b6.page_clk);
            chk("run", runs[c], b6.page_run_length);
            chk("b6 type", 0, b6.mem_type);
            chk("b7 type", i < 3 ? 3 : mt, b7.mem_type);
            chk("cols", 8 + c, b7.col_bits);
            if (i < 3) begin
                chk("sd rcd", 2 + c, b7.row_to_col);
            end else begin
                chk("rcd", 1 + c, b7.row_to_col);
                chk("cas w", 1 + c[0], b7.col_pulse);
                chk("cas p", 1 + c[1], b7.col_precharge);
            end
        end
        for (int k = 0; k < 5; k++) begin
            wr(brc_pkg::SIZE_OFS, 32'(mapc[k]));
            repeat (4) @(negedge sys_clk);
            chk("size", mapm[k], size_mb);
        end
        chk("clk free", 1, sdram_clk_en);
        wr(brc_pkg::SIZE_OFS, 32'h00000010);
        repeat (5) @(negedge sys_clk);
        chk("clk gated", 0, sdram_clk_en);
        @(posedge sys_clk);
        sdram <= 1'b1;
        go <= 1'b1;
        @(posedge sys_clk);
        go <= 1'b0;
        @(posedge sys_clk);
        @(negedge sys_clk);
        chk("clk on", 1, sdram_clk_en);
        wr(brc_pkg::BANK7_OFS, 32'h0);
        repeat (6) @(negedge sys_clk);
        @(posedge sys_clk);
        sdram <= 1'b0;
        slow <= 1'b1;
        go <= 1'b1;
        @(posedge sys_clk);
        go <= 1'b0;
        wr(brc_pkg::BANK7_OFS, 32'h00000700);
        repeat (3) @(negedge sys_clk);
        chk("held", 1, b7.access_clk);
        repeat (25) @(negedge sys_clk);
        chk("new", 14, b7.access_clk);
        rf_run(32'h00008000, 11'h7f7, 1);
        rf_run(32'h00018000, 11'h7f8, 0);
        wr(brc_pkg::RFSH_OFS, 32'h00c00000);
        repeat (10) @(negedge sys_clk);
        chk("self", 3'h0, pins);
        wr(brc_pkg::RFSH_OFS, 32'h0);
        repeat (20) @(negedge sys_clk);
        chk("exit", 3'h7, pins);
        chk("idle", 0, refresh_busy);
        wrap_up();
    end
endmodule : brc_bank67_tb
